//--- logic/tdvc_defs.vh
// Register map, field positions and reset values of the timer DMA/vector control bank
`ifndef TDVC_DEFS_VH
`define TDVC_DEFS_VH
// Printed offsets are register indexes; byte address is four times the index
`define TDVC_IDX_DAP_EVEN 8'hF1
`define TDVC_IDX_IVB_EVEN 8'hF2
`define TDVC_IDX_IDC_EVEN 8'hF3
`define TDVC_IDX_DAP_ODD 8'hF5
`define TDVC_IDX_IVB_ODD 8'hF6
`define TDVC_IDX_IDC_ODD 8'hF7
`define TDVC_IDX_IOL 8'hF8
// Control bank fields
`define TDVC_CPE_BIT 7
`define TDVC_CME_BIT 6
`define TDVC_SRC_BIT 5
`define TDVC_DST_BIT 4
`define TDVC_SWAP_BIT 3
`define TDVC_PTR_TOGGLE_BIT 2
`define TDVC_DIR_BIT 1
`define TDVC_MEM_BIT 0
// Vector group codes
`define TDVC_GRP_OVF 2'h0
`define TDVC_GRP_CAP 2'h2
`define TDVC_GRP_CMP 2'h3
// Reset values
`define TDVC_RST_DAP 8'h00
`define TDVC_RST_IVB 8'h00
`define TDVC_RST_IDC 8'hC7
`define TDVC_RST_IOL 8'hFC
// AXI responses
`define TDVC_RESP_OKAY 2'h0
`define TDVC_RESP_SLVERR 2'h2
`endif

//--- logic/tdvc_regs.v
// Timer DMA pointer, interrupt vector, DMA control and loopback register bank
`timescale 1ns/1ps
`default_nettype none
`include "tdvc_defs.vh"
module tdvc_regs #(
  parameter HAS_ODD_TIMER = 1
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // AXI4-Lite write address and data
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Timer DMA logic, index 0 even timer, 1 odd timer
  input wire [1:0] dma_compare_active,
  input wire [1:0] capture_eob_evt,
  input wire [1:0] compare_eob_evt,
  input wire [1:0] capture_swap_evt,
  input wire [1:0] area_select,
  // Interrupt controller: group being serviced per timer
  input wire [1:0] irq_grant,
  input wire [3:0] irq_group,
  // Output A and pin input A per timer
  input wire [1:0] timer_output_a,
  input wire [1:0] pin_input_a,
  // Decoded controls
  output reg [11:0] dma_ptr_upper,
  output reg [1:0] dma_area,
  output reg [15:0] vector_addr,
  output reg [1:0] capture_channel_source,
  output reg [1:0] compare_channel_dest,
  output reg [1:0] swap_enable,
  output reg [5:0] priority_level,
  output reg [1:0] timer_input_a
);
  reg [5:0] ptr_r [0:1];
  reg [4:0] vec_r [0:1];
  reg [1:0] grp_r [0:1];
  reg [1:0] ends_r [0:1];
  reg [5:0] ctl_r [0:1];
  reg [1:0] dir_r;
  reg [1:0] mem_r;
  reg [7:0] iol_r;
  reg [1:0] in0_meta_r;
  reg [1:0] in0_sync_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [11:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire do_write;
  wire [9:0] wr_idx;
  wire [9:0] rd_idx;
  wire [7:0] wbyte;
  wire wlane;
  reg [7:0] rd_val;
  reg rd_ok;
  reg wr_ok;
  // Per-register write strobes, one bit per timer copy, a single bit for the shared IOL
  reg [1:0] wr_dap;
  reg [1:0] wr_ivb;
  reg [1:0] wr_idc;
  reg wr_iol;
  // Qualified hardware events per timer
  wire [1:0] grp_ok;
  wire [1:0] swap_hit;
  integer i;

  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_idx = aw_addr_r[11:2];
  assign rd_idx = s_axi_araddr[11:2];
  assign wbyte = w_data_r[7:0];
  assign wlane = w_strb_r[0];

  // Group code 01 does not exist, such grants leave the code alone
  assign grp_ok[0] = irq_grant[0] && irq_group[1:0] != 2'h1;
  assign grp_ok[1] = irq_grant[1] && irq_group[3:2] != 2'h1;

  // Pointer toggle only while swap mode is on for that timer
  assign swap_hit[0] = capture_swap_evt[0] && ctl_r[0][`TDVC_SWAP_BIT];
  assign swap_hit[1] = capture_swap_evt[1] && ctl_r[1][`TDVC_SWAP_BIT];

  // Address decode for writes
  always @* begin
    wr_ok = 1'b0;
    if (wr_idx == {2'h0, `TDVC_IDX_DAP_EVEN} || wr_idx == {2'h0, `TDVC_IDX_IVB_EVEN} ||
        wr_idx == {2'h0, `TDVC_IDX_IDC_EVEN} || wr_idx == {2'h0, `TDVC_IDX_IOL}) begin
      wr_ok = 1'b1;
    end else if (HAS_ODD_TIMER != 0 && (wr_idx == {2'h0, `TDVC_IDX_DAP_ODD} ||
        wr_idx == {2'h0, `TDVC_IDX_IVB_ODD} || wr_idx == {2'h0, `TDVC_IDX_IDC_ODD})) begin
      wr_ok = 1'b1;
    end
  end

  // Full index compare; partial index bits alias odd and even copies
  always @* begin
    wr_dap = 2'h0;
    wr_ivb = 2'h0;
    wr_idc = 2'h0;
    wr_iol = 1'b0;
    // Only byte lane 0 carries the 8-bit registers
    if (do_write && wlane && wr_ok) begin
      if (wr_idx == {2'h0, `TDVC_IDX_DAP_EVEN}) begin
        wr_dap[0] = 1'b1;
      end else if (wr_idx == {2'h0, `TDVC_IDX_IVB_EVEN}) begin
        wr_ivb[0] = 1'b1;
      end else if (wr_idx == {2'h0, `TDVC_IDX_IDC_EVEN}) begin
        wr_idc[0] = 1'b1;
      end else if (wr_idx == {2'h0, `TDVC_IDX_IOL}) begin
        wr_iol = 1'b1;
      end else if (wr_idx == {2'h0, `TDVC_IDX_DAP_ODD}) begin
        wr_dap[1] = 1'b1;
      end else if (wr_idx == {2'h0, `TDVC_IDX_IVB_ODD}) begin
        wr_ivb[1] = 1'b1;
      end else if (wr_idx == {2'h0, `TDVC_IDX_IDC_ODD}) begin
        wr_idc[1] = 1'b1;
      end
    end
  end

  // Read decode
  always @* begin
    rd_ok = 1'b1;
    rd_val = 8'h00;
    if (rd_idx == {2'h0, `TDVC_IDX_DAP_EVEN}) begin
      rd_val = {ptr_r[0], dir_r[0], mem_r[0]};
    end else if (rd_idx == {2'h0, `TDVC_IDX_IVB_EVEN}) begin
      rd_val = {vec_r[0], grp_r[0], 1'b0};
    end else if (rd_idx == {2'h0, `TDVC_IDX_IDC_EVEN}) begin
      rd_val = {ends_r[0], ctl_r[0]};
    end else if (rd_idx == {2'h0, `TDVC_IDX_IOL}) begin
      rd_val = iol_r;
    end else if (HAS_ODD_TIMER != 0 && rd_idx == {2'h0, `TDVC_IDX_DAP_ODD}) begin
      rd_val = {ptr_r[1], dir_r[1], mem_r[1]};
    end else if (HAS_ODD_TIMER != 0 && rd_idx == {2'h0, `TDVC_IDX_IVB_ODD}) begin
      rd_val = {vec_r[1], grp_r[1], 1'b0};
    end else if (HAS_ODD_TIMER != 0 && rd_idx == {2'h0, `TDVC_IDX_IDC_ODD}) begin
      rd_val = {ends_r[1], ctl_r[1]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI write channel capture, either order
  always @(posedge clk) begin
    if (reset) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TDVC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `TDVC_RESP_OKAY : `TDVC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
    end
  end

  // AXI read channel
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TDVC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_ok ? `TDVC_RESP_OKAY : `TDVC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Per-timer register copies and the shared loopback register
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 2; i = i + 1) begin
        ptr_r[i] <= 6'h00;
        vec_r[i] <= 5'h00;
        grp_r[i] <= `TDVC_GRP_OVF;
        ends_r[i] <= 2'h3;
        ctl_r[i] <= 6'h07;
      end
      mem_r <= 2'h0;
      dir_r <= 2'h0;
      iol_r <= `TDVC_RST_IOL;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        dir_r[i] <= dma_compare_active[i];
        if (grp_ok[i]) begin
          grp_r[i] <= irq_group[2*i +: 2];
        end
        if (wr_dap[i]) begin
          ptr_r[i] <= wbyte[7:2];
          mem_r[i] <= wbyte[`TDVC_MEM_BIT];
        end
        if (wr_ivb[i]) begin
          vec_r[i] <= wbyte[7:3];
        end
        // Toggle after a same-cycle write: hardware wins on that bit
        if (swap_hit[i]) begin
          ptr_r[i][0] <= ~ptr_r[i][0];
        end
        // End flags: write may clear, hardware set wins, forced without swap
        if (wr_idc[i]) begin
          ctl_r[i] <= wbyte[5:0];
          ends_r[i] <= wbyte[7:6] | {capture_eob_evt[i], compare_eob_evt[i]};
          if (!wbyte[`TDVC_SWAP_BIT]) begin
            ends_r[i] <= 2'h3;
          end
        end else if (!ctl_r[i][`TDVC_SWAP_BIT]) begin
          ends_r[i] <= 2'h3;
        end else begin
          if (capture_eob_evt[i]) begin
            ends_r[i][1] <= 1'b1;
          end
          if (compare_eob_evt[i]) begin
            ends_r[i][0] <= 1'b1;
          end
        end
      end
      // Unused upper bits stay at their reset ones
      if (wr_iol) begin
        iol_r <= {6'h3F, wbyte[1:0]};
      end
    end
  end

  // Pin input A synchroniser
  always @(posedge clk) begin
    if (reset) begin
      in0_meta_r <= 2'h0;
      in0_sync_r <= 2'h0;
    end else begin
      in0_meta_r <= pin_input_a;
      in0_sync_r <= in0_meta_r;
    end
  end

  // Registered decoded outputs
  always @(posedge clk) begin
    if (reset) begin
      dma_ptr_upper <= 12'h000;
      dma_area <= 2'h0;
      vector_addr <= 16'h0000;
      capture_channel_source <= 2'h0;
      compare_channel_dest <= 2'h0;
      swap_enable <= 2'h0;
      priority_level <= 6'h3F;
      timer_input_a <= 2'h0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        dma_ptr_upper[6*i +: 6] <= ptr_r[i];
        // Area 1 means register file, 0 means memory per memory bit
        dma_area[i] <= area_select[i] | mem_r[i];
        vector_addr[8*i +: 8] <= {vec_r[i], grp_r[i], 1'b0};
        capture_channel_source[i] <= ctl_r[i][`TDVC_SRC_BIT];
        compare_channel_dest[i] <= ctl_r[i][`TDVC_DST_BIT];
        swap_enable[i] <= ctl_r[i][`TDVC_SWAP_BIT];
        priority_level[3*i +: 3] <= ctl_r[i][2:0];
      end
      timer_input_a[0] <= iol_r[0] ? timer_output_a[0] : in0_sync_r[0];
      timer_input_a[1] <= iol_r[1] ? timer_output_a[1] : in0_sync_r[1];
    end
  end
endmodule // tdvc_regs
`default_nettype wire

//--- test/tdvc_far.sv
// Timer DMA logic, interrupt controller and pin model facing the register bank
`timescale 1ns/1ps
`default_nettype none
module tdvc_far (
  // Clock
  input wire logic clk,
  // Timer DMA logic
  output var logic [1:0] dma_compare_active = 2'h0,
  output var logic [1:0] capture_eob_evt = 2'h0,
  output var logic [1:0] compare_eob_evt = 2'h0,
  output var logic [1:0] capture_swap_evt = 2'h0,
  output var logic [1:0] area_select = 2'h0,
  // Interrupt controller
  output var logic [1:0] irq_grant = 2'h0,
  output var logic [3:0] irq_group = 4'h0,
  // Timer output A and pin A
  output var logic [1:0] timer_output_a = 2'h0,
  output var logic [1:0] pin_input_a = 2'h0
);
  // One-cycle DMA event: 0 capture end, 1 compare end, else swap
  task automatic pulse(input int k, input int t);
    @(posedge clk);
    case (k)
      0: capture_eob_evt[t] <= 1'b1;
      1: compare_eob_evt[t] <= 1'b1;
      default: capture_swap_evt[t] <= 1'b1;
    endcase
    @(posedge clk);
    capture_eob_evt <= 2'h0;
    compare_eob_evt <= 2'h0;
    capture_swap_evt <= 2'h0;
  endtask
  task automatic grant(input int t, input logic [1:0] g);
    @(posedge clk);
    irq_group[2*t+:2] <= g;
    irq_grant[t] <= 1'b1;
    @(posedge clk);
    irq_grant <= 2'h0;
  endtask
endmodule // tdvc_far
`default_nettype wire

//--- test/tdvc_regs_checker.sv
// Port assertions for the timer DMA/vector register bank
`timescale 1ns/1ps
`default_nettype none
module tdvc_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer side
  input wire logic [1:0] capture_swap_evt,
  input wire logic [1:0] area_select,
  input wire logic [1:0] irq_grant,
  input wire logic [3:0] irq_group,
  input wire logic [11:0] dma_ptr_upper,
  input wire logic [1:0] dma_area,
  input wire logic [15:0] vector_addr,
  input wire logic [1:0] swap_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_aw_req; s_axi_awready |-> s_axi_awvalid; endproperty
  a_aw_req: assert property (p_aw_req) else $error("address taken without request");
  property p_vec_zero; vector_addr[0] == 1'b0 && vector_addr[8] == 1'b0; endproperty
  a_vec_zero: assert property (p_vec_zero) else $error("vector bit 0 not zero");
  property p_no_01; vector_addr[2:1] != 2'h1 && vector_addr[10:9] != 2'h1; endproperty
  a_no_01: assert property (p_no_01) else $error("reserved group code shown");
  property p_grp;
    irq_grant[0] && irq_group[1:0] != 2'h1 |-> ##2 vector_addr[2:1] == $past(irq_group[1:0], 2);
  endproperty
  a_grp: assert property (p_grp) else $error("group code not latched");
  property p_swap;
    capture_swap_evt[0] && swap_enable[0] |-> ##2 dma_ptr_upper[0] != $past(dma_ptr_upper[0], 2);
  endproperty
  a_swap: assert property (p_swap) else $error("swap did not toggle pointer");
  property p_area; area_select[0] [*3] |-> dma_area[0]; endproperty
  a_area: assert property (p_area) else $error("register file area not chosen");
endmodule // tdvc_regs_checker
bind tdvc_regs tdvc_regs_checker i_tdvc_regs_checker (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .capture_swap_evt, .area_select, .irq_grant, .irq_group, .dma_ptr_upper, .dma_area,
  .vector_addr, .swap_enable);
`default_nettype wire

//--- test/tdvc_regs_test.sv
// Self-checking bench of the timer DMA/vector register bank
`timescale 1ns/1ps
`default_nettype none
`include "tdvc_defs.vh"
module tdvc_regs_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, dma_compare_active, capture_eob_evt, compare_eob_evt;
  wire logic [1:0] capture_swap_evt, area_select, irq_grant, timer_output_a, pin_input_a, dma_area;
  wire logic [1:0] capture_channel_source, compare_channel_dest, swap_enable, timer_input_a;
  wire logic [3:0] irq_group;
  wire logic [31:0] s_axi_rdata;
  wire logic [11:0] dma_ptr_upper;
  wire logic [15:0] vector_addr;
  wire logic [5:0] priority_level;
  int n_fail = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  tdvc_far i_tdvc_far (.clk, .dma_compare_active, .capture_eob_evt, .compare_eob_evt,
    .capture_swap_evt, .area_select, .irq_grant, .irq_group, .timer_output_a, .pin_input_a);
  tdvc_regs i_tdvc_regs (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dma_compare_active, .capture_eob_evt, .compare_eob_evt, .capture_swap_evt,
    .area_select, .irq_grant, .irq_group, .timer_output_a, .pin_input_a, .dma_ptr_upper,
    .dma_area, .vector_addr, .capture_channel_source, .compare_channel_dest, .swap_enable,
    .priority_level, .timer_input_a);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    s_axi_awaddr <= {2'h0, ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    s_axi_araddr <= {2'h0, ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
    if (er == 2'h0) chk(s_axi_rdata, {24'h0, d});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset;
    chk(32'(priority_level), 32'h3F);
    rd(8'hF1, 8'h00);
    rd(8'hF2, 8'h00);
    rd(8'hF3, 8'hC7);
    rd(8'hF7, 8'hC7);
    rd(8'hF8, 8'hFC);
    rd(8'hF4, 8'h00, `TDVC_RESP_SLVERR);
    wr(8'hF4, 8'h55, `TDVC_RESP_SLVERR);
    $display("reset values done");
  endtask
  task automatic t_regs;
    wr(8'hF1, 8'hFF);
    rd(8'hF1, 8'hFD);
    i_tdvc_far.dma_compare_active[0] <= 1'b1;
    rd(8'hF1, 8'hFF);
    wr(8'hF2, 8'hFF);
    rd(8'hF2, 8'hF8);
    wr(8'hF3, 8'hF8);
    rd(8'hF7, 8'hC7);
    chk(32'(capture_channel_source), 32'h1);
    chk(32'(compare_channel_dest), 32'h1);
    chk(32'(swap_enable), 32'h1);
    chk(32'(priority_level), 32'h38);
    $display("register fields done");
  endtask
  task automatic t_swap;
    wr(8'hF3, 8'h38);
    rd(8'hF3, 8'h38);
    i_tdvc_far.pulse(0, 0);
    rd(8'hF3, 8'hB8);
    i_tdvc_far.pulse(1, 0);
    rd(8'hF3, 8'hF8);
    i_tdvc_far.pulse(2, 0);
    rd(8'hF1, 8'hFB);
    wr(8'hF3, 8'h07);
    rd(8'hF3, 8'hC7);
    $display("swap and block end done");
  endtask
  task automatic t_vec;
    i_tdvc_far.grant(0, 2'h2);
    rd(8'hF2, 8'hFC);
    i_tdvc_far.grant(0, 2'h3);
    rd(8'hF2, 8'hFE);
    i_tdvc_far.grant(0, 2'h1);
    rd(8'hF2, 8'hFE);
    i_tdvc_far.grant(0, 2'h0);
    rd(8'hF2, 8'hF8);
    chk(32'(vector_addr[7:0]), 32'hF8);
    $display("vector groups done");
  endtask
  task automatic t_area;
    chk(32'(dma_area), 32'h1);
    wr(8'hF1, 8'hF8);
    repeat (2) @(posedge clk);
    chk(32'(dma_area), 32'h0);
    chk(32'(dma_ptr_upper[5:0]), 32'h3E);
    i_tdvc_far.area_select <= 2'h1;
    repeat (3) @(posedge clk);
    chk(32'(dma_area), 32'h1);
    $display("area select done");
  endtask
  task automatic t_loop;
    i_tdvc_far.timer_output_a <= 2'h1;
    i_tdvc_far.pin_input_a <= 2'h2;
    repeat (6) @(posedge clk);
    chk(32'(timer_input_a), 32'h2);
    wr(8'hF8, 8'h03);
    rd(8'hF8, 8'hFF);
    repeat (6) @(posedge clk);
    chk(32'(timer_input_a), 32'h1);
    wr(8'hF8, 8'h01);
    repeat (6) @(posedge clk);
    chk(32'(timer_input_a), 32'h3);
    $display("loopback done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_regs;
    t_swap;
    t_vec;
    t_area;
    t_loop;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule // tdvc_regs_test
`default_nettype wire
